// *** lpsc_panel_ctrl.sv ***
// panel power sequencing, gate supply control, serial register intake and pixel capture
// assumes an apb master on clk_sys_in and a host driving pixel clock, syncs and serial lines
`timescale 1ns/10ps
module lpsc_panel_ctrl (
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire logic pixel_clock_pin,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic shutdown_in,
	input wire logic active_low_panel_reset_n_in,
	input wire logic vsync_n_in,
	input wire lpsc_pkg::lpsc_pixel_t pixel_in,
	input wire logic serial_cs_n_in,
	input wire logic serial_clk_in,
	input wire logic serial_data_input_in,
	output logic gate_high_boost_out,
	output logic display_on_out,
	output lpsc_pkg::lpsc_pixel_t pixel_out,
	output logic reg_write_out,
	output lpsc_pkg::lpsc_reg_write_t reg_write_data_out
);
	import lpsc_pkg::*;

	// pixel clock domain
	logic rst_pix_s1_q, rst_pix_q;
	logic shut_s1_q, shut_s2_q, active_low_panel_reset_p1_q, active_low_panel_reset_p2_q;
	logic vsync_prev_q, pix_toggle_q, disp_q, pwr_on_q;
	logic [8:0] clk_cnt_q;
	logic [7:0] line_cnt_q;
	logic [3:0] frame_cnt_q, vs_cnt_q;
	lpsc_state_t st_q, st_d;
	lpsc_pixel_t pixel_q;
	logic boost_allow_q;

	wire vs_fall = vsync_prev_q & ~vsync_n_in;
	wire line_end = (clk_cnt_q == LPSC_LINE_CLKS - 9'h1);
	wire frame_end = line_end & (line_cnt_q == LPSC_FRAME_LINES - 8'h1);
	wire up_done = (st_q == LPSC_UP) & vs_fall & (vs_cnt_q == LPSC_UP_FRAMES - 4'h1);
	wire down_done = (st_q == LPSC_DOWN) & vs_fall & (vs_cnt_q == LPSC_DOWN_FRAMES - 4'h1);
	// image stays up through power-down until the second vsync fall
	wire disp_d = (st_d == LPSC_ON) | (disp_q & (st_d == LPSC_DOWN));

	always_ff @(posedge pixel_clock_pin) begin
		rst_pix_s1_q <= srst_in;
		rst_pix_q <= rst_pix_s1_q;
		shut_s1_q <= shutdown_in;
		shut_s2_q <= shut_s1_q;
		active_low_panel_reset_p1_q <= active_low_panel_reset_n_in;
		active_low_panel_reset_p2_q <= active_low_panel_reset_p1_q;
	end

	always_comb begin
		st_d = st_q;
		case (st_q)
			LPSC_OFF: if (!shut_s2_q) st_d = LPSC_UP;
			LPSC_UP: begin
				if (shut_s2_q) st_d = LPSC_DOWN;
				else if (up_done) st_d = LPSC_ON;
			end
			LPSC_ON: if (shut_s2_q) st_d = LPSC_DOWN;
			LPSC_DOWN: if (down_done) st_d = LPSC_OFF;
			default: st_d = LPSC_OFF;
		endcase
		// panel reset restarts the whole power sequence
		if (!active_low_panel_reset_p2_q) st_d = LPSC_OFF;
	end

	always_ff @(posedge pixel_clock_pin) begin
		if (rst_pix_q) begin
			st_q <= LPSC_OFF;
			vsync_prev_q <= 1'b1;
			pix_toggle_q <= 1'b0;
			clk_cnt_q <= 9'h0;
			line_cnt_q <= 8'h0;
			frame_cnt_q <= 4'h0;
			vs_cnt_q <= 4'h0;
			disp_q <= 1'b0;
			pwr_on_q <= 1'b0;
			pixel_q <= '0;
		end else begin
			st_q <= st_d;
			vsync_prev_q <= vsync_n_in;
			pix_toggle_q <= ~pix_toggle_q;
			clk_cnt_q <= (st_q == LPSC_OFF || line_end) ? 9'h0 : clk_cnt_q + 9'h1;
			if (st_q == LPSC_OFF || frame_end)
				line_cnt_q <= 8'h0;
			else if (line_end)
				line_cnt_q <= line_cnt_q + 8'h1;
			if (st_q == LPSC_OFF)
				frame_cnt_q <= 4'h0;
			else if (frame_end && frame_cnt_q != LPSC_UP_FRAMES)
				frame_cnt_q <= frame_cnt_q + 4'h1;
			// vsync falls counted afresh on each state entry
			if (st_d != st_q)
				vs_cnt_q <= 4'h0;
			else if (vs_fall && (st_q == LPSC_UP || st_q == LPSC_DOWN))
				vs_cnt_q <= vs_cnt_q + 4'h1;
			disp_q <= disp_d;
			if (st_d == LPSC_OFF)
				pwr_on_q <= 1'b0;
			else if (up_done || (st_q == LPSC_UP && frame_cnt_q == LPSC_UP_FRAMES))
				pwr_on_q <= 1'b1;
			pixel_q <= disp_d ? pixel_in : '0;
		end
	end

	assign pixel_out = pixel_q;

	// system clock domain
	logic disp_s1_q, disp_s2_q, pwr_s1_q, pwr_s2_q, tog_s1_q, tog_s2_q, tog_s3_q;
	logic active_low_panel_reset_s1_q, active_low_panel_reset_s2_q, gate_boost_q, clk_alive_q;
	logic [5:0] loss_cnt_q;
	logic cs_s1_q, cs_s2_q, sclk_s1_q, sclk_s2_q, sclk_s3_q, sdi_s1_q, sdi_s2_q;
	logic [3:0] bit_cnt_q;
	logic [1:0] wcnt_q;
	logic [7:0] shift_q, addr_q, hi_q;
	logic serr_q, reg_wr_q;
	lpsc_reg_write_t reg_wd_q;
	logic [31:0] wr_count_q, prdata_q;

	always_ff @(posedge clk_sys_in) begin
		disp_s1_q <= disp_q;
		disp_s2_q <= disp_s1_q;
		pwr_s1_q <= pwr_on_q;
		pwr_s2_q <= pwr_s1_q;
		tog_s1_q <= pix_toggle_q;
		tog_s2_q <= tog_s1_q;
		tog_s3_q <= tog_s2_q;
		active_low_panel_reset_s1_q <= active_low_panel_reset_n_in;
		active_low_panel_reset_s2_q <= active_low_panel_reset_s1_q;
		cs_s1_q <= serial_cs_n_in;
		cs_s2_q <= cs_s1_q;
		sclk_s1_q <= serial_clk_in;
		sclk_s2_q <= sclk_s1_q;
		sclk_s3_q <= sclk_s2_q;
		sdi_s1_q <= serial_data_input_in;
		sdi_s2_q <= sdi_s1_q;
	end

	// no boost can be made once the pixel clock stops, so the gate falls back to the rail
	wire tog_seen = tog_s2_q ^ tog_s3_q;
	wire boost_d = pwr_s2_q & clk_alive_q & boost_allow_q & active_low_panel_reset_s2_q;

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			loss_cnt_q <= 6'h0;
			clk_alive_q <= 1'b0;
			gate_boost_q <= 1'b0;
		end else begin
			loss_cnt_q <= tog_seen ? 6'h0 : (clk_alive_q ? loss_cnt_q + 6'h1 : 6'h0);
			clk_alive_q <= tog_seen | (clk_alive_q & (loss_cnt_q != LPSC_CLK_LOSS_CYCLES));
			gate_boost_q <= boost_d;
		end
	end

	assign gate_high_boost_out = gate_boost_q;
	assign display_on_out = disp_s2_q;

	// serial intake; sclk is oversampled, so it must stay well below half the system rate
	wire sclk_rise = sclk_s2_q & ~sclk_s3_q & ~cs_s2_q;
	wire word_done = sclk_rise & (bit_cnt_q == LPSC_WORD_BITS - 4'h1);
	wire [8:0] word = {shift_q, sdi_s2_q};
	wire flag_ok = (wcnt_q == 2'h0) ? ~word[8] : word[8];
	wire serr_set = word_done & ~flag_ok;
	wire write_done = word_done & flag_ok & (wcnt_q == 2'h2);

	always_ff @(posedge clk_sys_in) begin
		if (srst_in || cs_s2_q) begin
			bit_cnt_q <= 4'h0;
			wcnt_q <= 2'h0;
			shift_q <= 8'h0;
		end else if (sclk_rise) begin
			shift_q <= word[7:0];
			bit_cnt_q <= word_done ? 4'h0 : bit_cnt_q + 4'h1;
			if (word_done)
				wcnt_q <= (flag_ok && wcnt_q != 2'h2) ? wcnt_q + 2'h1 : 2'h0;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			addr_q <= 8'h0;
			hi_q <= 8'h0;
			reg_wr_q <= 1'b0;
			reg_wd_q <= '0;
			wr_count_q <= 32'h0;
		end else begin
			reg_wr_q <= write_done;
			if (word_done && flag_ok && wcnt_q == 2'h0)
				addr_q <= word[7:0];
			if (word_done && flag_ok && wcnt_q == 2'h1)
				hi_q <= word[7:0];
			if (write_done) begin
				reg_wd_q <= '{addr: addr_q, data: {hi_q, word[7:0]}};
				wr_count_q <= wr_count_q + 32'h1;
			end
		end
	end

	assign reg_write_out = reg_wr_q;
	assign reg_write_data_out = reg_wd_q;

	// apb slave: zero wait states, read data captured in the setup cycle
	wire setup = psel & ~penable;
	wire access = psel & penable;
	wire hit_ctrl = (paddr == LPSC_CTRL_OFS);
	wire hit_stat = (paddr == LPSC_STATUS_OFS);
	wire hit_last = (paddr == LPSC_LAST_WR_OFS);
	wire hit_cnt = (paddr == LPSC_WR_COUNT_OFS);
	wire mapped = hit_ctrl | hit_stat | hit_last | hit_cnt;
	wire [31:0] status_word = 32'({serr_q, clk_alive_q, gate_boost_q, pwr_s2_q, disp_s2_q});
	wire [31:0] rd_mux = hit_ctrl ? 32'(boost_allow_q) :
		hit_stat ? status_word :
		hit_last ? 32'(reg_wd_q) :
		hit_cnt ? wr_count_q : 32'h0;
	wire serr_clr = access & pwrite & hit_stat & pwdata[LPSC_ST_SERR_BIT];

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			boost_allow_q <= LPSC_CTRL_BOOST_RST;
			serr_q <= 1'b0;
			prdata_q <= 32'h0;
		end else begin
			if (access && pwrite && hit_ctrl)
				boost_allow_q <= pwdata[LPSC_CTRL_BOOST_BIT];
			// set wins over clear
			serr_q <= serr_set | (serr_q & ~serr_clr);
			if (setup)
				prdata_q <= rd_mux;
		end
	end

	assign prdata = prdata_q;
	assign pready = access;
	assign pslverr = access & ~mapped;

	// checks
	a_gate_rail_reset: assert property (@(posedge clk_sys_in) disable iff (srst_in)
		!active_low_panel_reset_n_in |-> ##3 !gate_boost_q)
		else $error("gate supply boosted while panel reset low");
	a_display_tenth_vs: assert property (@(posedge pixel_clock_pin) disable iff (rst_pix_q)
		(st_q == LPSC_UP && vs_fall && vs_cnt_q == 4'h9 && !shut_s2_q && active_low_panel_reset_p2_q) |=> disp_q)
		else $error("display did not start on tenth vsync fall");
	a_display_not_early: assert property (@(posedge pixel_clock_pin) disable iff (rst_pix_q)
		(st_q == LPSC_UP) |-> (vs_cnt_q < LPSC_UP_FRAMES && !disp_q))
		else $error("display started early");
	a_power_on_bound: assert property (@(posedge pixel_clock_pin) disable iff (rst_pix_q)
		(st_q == LPSC_UP && frame_cnt_q == LPSC_UP_FRAMES && active_low_panel_reset_p2_q && !shut_s2_q) |=> pwr_on_q)
		else $error("panel power on later than ten frames");
	a_line_length: assert property (@(posedge pixel_clock_pin) disable iff (rst_pix_q)
		(clk_cnt_q == 9'h0 && $past(clk_cnt_q) != 9'h0 && $past(st_q) != LPSC_OFF) |->
		$past(clk_cnt_q) == LPSC_LINE_CLKS - 9'h1)
		else $error("line length is not 336 clocks");
	a_frame_length: assert property (@(posedge pixel_clock_pin) disable iff (rst_pix_q)
		(line_end && st_q != LPSC_OFF) |-> line_cnt_q < LPSC_FRAME_LINES)
		else $error("frame longer than 244 lines");
	a_display_off_2nd: assert property (@(posedge pixel_clock_pin) disable iff (rst_pix_q)
		(st_q == LPSC_DOWN && vs_fall && vs_cnt_q == 4'h1) |=> (st_q == LPSC_OFF && !disp_q))
		else $error("display not off on second vsync fall");
	a_write_three_words: assert property (@(posedge clk_sys_in) disable iff (srst_in)
		reg_wr_q |-> ($past(wcnt_q) == 2'h2 &&
		reg_wd_q.data[7:0] == {$past(shift_q[6:0]), $past(sdi_s2_q)}))
		else $error("register write not formed from third word");
	a_flag_error: assert property (@(posedge clk_sys_in) disable iff (srst_in)
		(word_done && wcnt_q == 2'h0 && word[8]) |=> (serr_q && wcnt_q == 2'h0))
		else $error("address word with data flag accepted");
	a_cs_ignores: assert property (@(posedge clk_sys_in) disable iff (srst_in)
		cs_s2_q |=> (bit_cnt_q == 4'h0 && !reg_wr_q))
		else $error("serial state advanced while deselected");
	a_pixel_word: assert property (@(posedge pixel_clock_pin) disable iff (rst_pix_q)
		(st_d == LPSC_ON) |=> pixel_q == $past(pixel_in))
		else $error("pixel word not captured");

	c_power_up: cover property (@(posedge pixel_clock_pin) disable iff (rst_pix_q) up_done);
	c_power_down: cover property (@(posedge pixel_clock_pin) disable iff (rst_pix_q) down_done);
	c_reg_write: cover property (@(posedge clk_sys_in) disable iff (srst_in) reg_wr_q);
	c_boost: cover property (@(posedge clk_sys_in) disable iff (srst_in) $rose(gate_boost_q));

endmodule

// *** lpsc_pkg.sv ***
// package for the panel power and serial control block
// assumes a 40 MHz system clock and a host-driven pixel clock
package lpsc_pkg;

	// apb register byte offsets
	localparam logic [7:0] LPSC_CTRL_OFS = 8'h00;
	localparam logic [7:0] LPSC_STATUS_OFS = 8'h04;
	localparam logic [7:0] LPSC_LAST_WR_OFS = 8'h08;
	localparam logic [7:0] LPSC_WR_COUNT_OFS = 8'h0c;

	// field positions
	localparam int LPSC_CTRL_BOOST_BIT = 0;
	localparam int LPSC_ST_DISPLAY_BIT = 0;
	localparam int LPSC_ST_POWER_BIT = 1;
	localparam int LPSC_ST_BOOST_BIT = 2;
	localparam int LPSC_ST_CLK_BIT = 3;
	localparam int LPSC_ST_SERR_BIT = 4;

	// reset values
	localparam logic LPSC_CTRL_BOOST_RST = 1'b1;

	// frame timing, counted in pixel clocks, lines and frames
	localparam logic [8:0] LPSC_LINE_CLKS = 9'h150;
	localparam logic [7:0] LPSC_FRAME_LINES = 8'hf4;
	localparam logic [3:0] LPSC_UP_FRAMES = 4'ha;
	localparam logic [3:0] LPSC_DOWN_FRAMES = 4'h2;

	// system clock and pixel clock loss detection
	localparam int LPSC_SYS_CLK_MHZ = 40;
	localparam int LPSC_CLK_LOSS_NS = 800;
	localparam logic [5:0] LPSC_CLK_LOSS_CYCLES = 6'(LPSC_CLK_LOSS_NS * LPSC_SYS_CLK_MHZ / 1000);

	// serial framing
	localparam logic [3:0] LPSC_WORD_BITS = 4'h9;

	typedef enum {
		LPSC_OFF,
		LPSC_UP,
		LPSC_ON,
		LPSC_DOWN
	} lpsc_state_t;

	typedef struct packed {
		logic [5:0] red_component_bits;
		logic [5:0] green_component_bits;
		logic [5:0] blue_component_bits;
	} lpsc_pixel_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] data;
	} lpsc_reg_write_t;

endpackage

// *** lpsc_host.sv ***
// host display controller model: pixel clock, vertical sync, serial writes
// assumes the bench calls its tasks and clk_in paces the serial link
`timescale 1ns/10ps
module lpsc_host (
	input wire logic clk_in,
	output logic pclk_out,
	output logic vsync_n_out,
	output logic cs_n_out,
	output logic sclk_out,
	output logic sdata_out
);
	initial begin
		pclk_out = 1'b0;
		vsync_n_out = 1'b1;
		cs_n_out = 1'b1;
		sclk_out = 1'b0;
		sdata_out = 1'b0;
	end
	initial begin
		#3.3;
		forever #6 pclk_out = ~pclk_out;
	end
	// short frames, one sync fall each
	task automatic frames(input int n);
		repeat (n) begin
			repeat (20) @(posedge pclk_out);
			vsync_n_out <= 1'b0;
			repeat (20) @(posedge pclk_out);
			vsync_n_out <= 1'b1;
		end
	endtask
	task automatic word(input logic [8:0] w);
		for (int i = 8; i >= 0; i--) begin
			@(posedge clk_in) sdata_out <= w[i];
			repeat (4) @(posedge clk_in);
			sclk_out <= 1'b1;
			repeat (4) @(posedge clk_in);
			sclk_out <= 1'b0;
			// no stale data after the edge
			sdata_out <= ~w[i];
		end
	endtask
	// select low over all three words
	task automatic reg_write(input logic [7:0] a, input logic [15:0] d, input logic bad);
		@(posedge clk_in) cs_n_out <= 1'b0;
		word({bad, a});
		word({1'b1, d[15:8]});
		word({1'b1, d[7:0]});
		repeat (4) @(posedge clk_in);
		cs_n_out <= 1'b1;
	endtask
endmodule

// *** tb.sv ***
// self-checking bench for the panel power and serial control block
// assumes lpsc_host stands in for the display controller
`timescale 1ns/10ps
module tb;
	import lpsc_pkg::*;
	logic clk_sys_in = 1'b0;
	logic srst_in = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic shutdown_in = 1'b1;
	logic active_low_panel_reset_n_in = 1'b1;
	lpsc_pixel_t pixel_in = 18'h0;
	lpsc_pixel_t pixel_out;
	lpsc_reg_write_t reg_write_data_out;
	logic pclk, vsync_n, cs_n, sclk, sdata;
	logic gate_high_boost_out, display_on_out, reg_write_out;
	int miscompares = 0;
	int n_checks = 0;
	int n_pulse = 0;
	logic [31:0] r;
	logic e;
	always #12.5 clk_sys_in = ~clk_sys_in;
	always @(posedge clk_sys_in) if (reg_write_out === 1'b1) n_pulse <= n_pulse + 1;
	lpsc_host host (.clk_in(clk_sys_in), .pclk_out(pclk), .vsync_n_out(vsync_n),
		.cs_n_out(cs_n), .sclk_out(sclk), .sdata_out(sdata));
	lpsc_panel_ctrl dut (.clk_sys_in, .srst_in, .pixel_clock_pin(pclk), .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .shutdown_in,
		.active_low_panel_reset_n_in, .vsync_n_in(vsync_n), .pixel_in,
		.serial_cs_n_in(cs_n), .serial_clk_in(sclk), .serial_data_input_in(sdata),
		.gate_high_boost_out, .display_on_out, .pixel_out, .reg_write_out,
		.reg_write_data_out);
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("checks %0d, mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// waits on pready with no fixed count; the watchdog cuts a hang
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys_in) penable <= 1'b1;
		do @(posedge clk_sys_in); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic t_regs();
		apb(1'b0, LPSC_CTRL_OFS, 32'h0);
		check(r, 32'h1);
		apb(1'b0, LPSC_WR_COUNT_OFS, 32'h0);
		check(r, 32'h0);
		apb(1'b1, 8'h10, 32'hffffffff);
		check(e, 1'b1);
		apb(1'b0, 8'h10, 32'h0);
		check(e, 1'b1);
		check(r, 32'h0);
		$display("test regs done");
	endtask
	task automatic t_serial();
		host.reg_write(8'h01, 16'h2aef, 1'b0);
		repeat (8) @(posedge clk_sys_in);
		check(n_pulse, 1);
		check(reg_write_data_out, 24'h012aef);
		apb(1'b0, LPSC_LAST_WR_OFS, 32'h0);
		check(r, 32'h00012aef);
		host.reg_write(8'h05, 16'h1234, 1'b1);
		repeat (8) @(posedge clk_sys_in);
		check(n_pulse, 1);
		apb(1'b0, LPSC_STATUS_OFS, 32'h0);
		check(r[LPSC_ST_SERR_BIT], 1'b1);
		apb(1'b1, LPSC_STATUS_OFS, 32'h10);
		apb(1'b0, LPSC_STATUS_OFS, 32'h0);
		check(r[LPSC_ST_SERR_BIT], 1'b0);
		apb(1'b0, LPSC_WR_COUNT_OFS, 32'h0);
		check(r, 32'h1);
		$display("test serial done");
	endtask
	task automatic t_up();
		@(posedge clk_sys_in) shutdown_in <= 1'b0;
		host.frames(9);
		repeat (8) @(posedge clk_sys_in);
		check(display_on_out, 1'b0);
		host.frames(1);
		repeat (8) @(posedge clk_sys_in);
		check(display_on_out, 1'b1);
		check(gate_high_boost_out, 1'b1);
		apb(1'b0, LPSC_STATUS_OFS, 32'h0);
		check(r, 32'hf);
		pixel_in <= {6'h3f, 6'h00, 6'h15};
		repeat (8) @(posedge clk_sys_in);
		check(pixel_out, 18'h3f015);
		pixel_in <= 18'h3ffff;
		repeat (8) @(posedge clk_sys_in);
		check(pixel_out, 18'h3ffff);
		$display("test power up done");
	endtask
	task automatic t_down();
		@(posedge clk_sys_in) shutdown_in <= 1'b1;
		host.frames(1);
		repeat (8) @(posedge clk_sys_in);
		check(display_on_out, 1'b1);
		host.frames(1);
		repeat (8) @(posedge clk_sys_in);
		check(display_on_out, 1'b0);
		check(pixel_out, 18'h0);
		$display("test power down done");
	endtask
	task automatic t_reset();
		apb(1'b1, LPSC_CTRL_OFS, 32'h0);
		repeat (4) @(posedge clk_sys_in);
		check(gate_high_boost_out, 1'b0);
		apb(1'b1, LPSC_CTRL_OFS, 32'h1);
		repeat (4) @(posedge clk_sys_in);
		check(gate_high_boost_out, 1'b1);
		@(posedge clk_sys_in) active_low_panel_reset_n_in <= 1'b0;
		repeat (4) @(posedge clk_sys_in);
		check(gate_high_boost_out, 1'b0);
		repeat (400) @(posedge clk_sys_in);
		check(gate_high_boost_out, 1'b0);
		active_low_panel_reset_n_in <= 1'b1;
		$display("test panel reset done");
	endtask
	initial begin
		repeat (8) @(posedge clk_sys_in);
		srst_in <= 1'b0;
		repeat (40) @(posedge clk_sys_in);
		t_regs();
		t_serial();
		t_up();
		t_down();
		// full cycle is twelve frames, ten up and two down
		t_up();
		t_reset();
		close_out();
	end
	initial begin
		repeat (20000) @(posedge clk_sys_in);
		miscompares++;
		close_out();
	end
endmodule
